// File: verilog/adclp_ctrl.sv
// converter control: registers, conversion sequence and stop-mode behaviour
//
// The implementer's own choices: the strobed register port and the register offsets.
`timescale 1ns/1ns

////////////////////////////////////////////////////////////////////////////////
// Overview of operation
// RULE1 - stop3 without async clock selected aborts conversion and goes idle
// RULE2 - stop3 entry or exit never changes the result bytes
// RULE3 - after an aborted stop3, stay idle until a new trigger
// RULE4 - with async clock selected, stop3 entry does not abort
// RULE5 - conversion running at stop3 entry completes on async clock
// RULE6 - in async stop3, hardware trigger and continuous mode start conversions
// RULE7 - completion sets the complete flag; enabled flag raises the interrupt
// RULE8 - stop1 or stop2 disables the block and resets every register
// RULE9 - software clears result blocking before stop3 with conversions running
// RULE10 - config: low power, divider, long sample, resolution, clock source
// RULE11 - resolution field 10 selects 10-bit conversions
// RULE12 - clock source 00 is bus clock; divider 00 is divide by one
// RULE13 - control two: active flag, trigger select, compare enable, direction
// RULE14 - control two bits 3:2 read zero; software writes zero to 1:0
// RULE15 - control one: complete flag, interrupt enable, continuous, channel
// RULE16 - channel 00001 routes input one; continuous 0 gives one conversion
// RULE17 - software reads high result byte before low byte
// RULE18 - software writes config, then control two, then control one
// RULE19 - inputs at or beyond references give full-scale or zero codes
// RULE20 - sample phase lasts 3.5 or 23.5 converter clocks; the code rounds up to 4 or 24 ticks
// RULE21 - conversions work regardless of pin control; set bit disables pin I/O
// RULE22 - a result between high and low byte reads is discarded, no flag
// RULE23 - active flag clears in the cycle the stop3 abort returns to idle
// RULE24 - stop3 behaviour follows clock source sampled at stop entry
module adclp_ctrl (
    // clock and reset
    input  wire logic                  clk,
    input  wire logic                  rstn,
    // register port
    input  wire adclp_pkg::adclp_bus_s bus,
    output logic [7:0]                 rdata,
    // power-mode controller
    input  wire logic                  stop3_mode,
    input  wire logic                  stop12_mode,
    // pins and analog front end
    input  wire logic                  hw_trigger_pin,
    input  wire logic                  async_clk_pin,
    input  wire logic                  alt_clk_pin,
    input  wire logic [10:0]           analog_level,
    // status and control outputs
    output logic                       irq_req,
    output logic                       conv_active,
    output logic                       sample_phase,
    output logic [4:0]                 channel_select_field,
    output logic [15:0]                pin_io_disable,
    output logic                       low_power_select
);
    import adclp_pkg::*;

    adclp_state_s s;
    adclp_state_s next_s;
    logic         tick;
    logic         stop_entry;
    logic         async_now;
    logic         halted;
    logic         hw_go;
    logic         wr_sc1;
    logic         wr_mode;
    logic         done;
    logic         transfer;
    logic         conv_complete_flag_set;
    logic         conv_complete_flag_clr;
    logic         cmp_ok;
    logic         mode10;
    logic [9:0]   code;
    logic [9:0]   cmp_val;
    logic [9:0]   diff;
    logic [5:0]   sample_len;
    logic [5:0]   conv_len;

    // saturate at the high reference; 8-bit mode keeps the upper bits
    function automatic logic [9:0] clamp_code(input logic [10:0] lvl, input logic m10);
        logic [9:0] c;
        c = (lvl >= {1'b0, FULL_10}) ? FULL_10 : lvl[9:0];
        clamp_code = m10 ? c : {2'h0, c[9:2]};
    endfunction

    function automatic logic is_addr(input adclp_bus_s b, input logic [3:0] a);
        is_addr = (b.addr == a);
    endfunction

    adclp_clkgen u_clkgen (
        .clk           (clk),
        .rstn          (rstn),
        .run           (s.active & ~halted & ~stop12_mode),
        .src_sel       (s.cfg[CFG_CLK +: 2]),
        .div_sel       (s.cfg[CFG_DIV +: 2]),
        .async_clk_pin (async_clk_pin),
        .alt_clk_pin   (alt_clk_pin),
        .tick          (tick)
    );

    ////////////////////////////////////////////////////////////////////////////
    always_comb begin
        next_s = s;
        next_s.rdata = 8'h00;
        next_s.trg1 = hw_trigger_pin;
        next_s.trg2 = s.trg1;
        next_s.trg3 = s.trg2;
        next_s.stop3_q = stop3_mode;
        stop_entry = stop3_mode & ~s.stop3_q;
        async_now = (s.cfg[CFG_CLK +: 2] == CLK_ASYNC);
        if (stop_entry) begin
            next_s.stop3_async = async_now; // RULE24
        end
        halted = stop3_mode & ~(stop_entry ? async_now : s.stop3_async); // RULE1 RULE4
        mode10 = (s.cfg[CFG_MODE +: 2] == MODE_10BIT); // RULE11
        sample_len = s.cfg[CFG_LSMP] ? SAMPLE_LONG_HALF : SAMPLE_SHORT_HALF; // RULE20
        conv_len = mode10 ? CONV_10_CYC : CONV_8_CYC;
        hw_go = s.trg2 & ~s.trg3 & s.trg & (s.ch != CH_OFF) & (s.st == ST_IDLE); // RULE6
        wr_sc1 = bus.wr & is_addr(bus, OFS_SC1);
        wr_mode = bus.wr & (is_addr(bus, OFS_CONFIG) | is_addr(bus, OFS_SC2)
                            | is_addr(bus, OFS_CMP_H) | is_addr(bus, OFS_CMP_L));
        code = clamp_code(s.sample_val, mode10); // RULE19
        cmp_val = mode10 ? {s.cmp_h[1:0], s.cmp_l} : {2'h0, s.cmp_l};
        diff = code - cmp_val;
        cmp_ok = s.cgt ? (code >= cmp_val) : (code < cmp_val);
        done = 1'b0;
        transfer = 1'b0;
        conv_complete_flag_set = 1'b0;
        conv_complete_flag_clr = 1'b0;

        case (s.st)
            ST_SAMPLE: begin
                if (tick) begin
                    // two half cycles per tick, so 3.5 rounds up to 4
                    if (s.cnt + 6'h02 >= sample_len) begin // RULE20
                        next_s.st = ST_CONVERT;
                        next_s.cnt = 6'h00;
                        next_s.sample_val = analog_level;
                    end else begin
                        next_s.cnt = s.cnt + 6'h02;
                    end
                end
            end
            ST_CONVERT: begin
                if (tick) begin
                    if (s.cnt + 6'h01 >= conv_len) begin
                        done = 1'b1; // RULE5
                    end else begin
                        next_s.cnt = s.cnt + 6'h01;
                    end
                end
            end
            default: begin
                if (hw_go) begin
                    next_s.st = ST_SAMPLE; // RULE6
                    next_s.cnt = 6'h00;
                end
            end
        endcase

        // a completion racing the stop3 abort is dropped
        if (done & ~halted) begin
            next_s.cnt = 6'h00;
            if (s.blocked) begin
                // result lost; retry unless a failed single compare ends it
                next_s.st = (s.cfe & ~cmp_ok & ~s.cont) ? ST_IDLE : ST_SAMPLE; // RULE22
            end else begin
                transfer = ~s.cfe | cmp_ok;
                conv_complete_flag_set = transfer; // RULE7
                next_s.st = s.cont ? ST_SAMPLE : ST_IDLE; // RULE6 RULE16
            end
        end
        if (transfer) begin
            next_s.res_h = mode10 ? {6'h00, (s.cfe ? diff[9:8] : code[9:8])} : 8'h00;
            next_s.res_l = s.cfe ? diff[7:0] : code[7:0];
        end

        // a mode change invalidates the running conversion
        if (wr_mode) begin
            next_s.st = ST_IDLE;
            next_s.cnt = 6'h00;
        end
        if (bus.wr) begin
            if (is_addr(bus, OFS_CONFIG)) begin
                next_s.cfg = bus.wdata; // RULE10
            end else if (is_addr(bus, OFS_SC2)) begin
                next_s.trg = bus.wdata[SC2_TRG]; // RULE13
                next_s.cfe = bus.wdata[SC2_CFE];
                next_s.cgt = bus.wdata[SC2_CGT];
            end else if (is_addr(bus, OFS_SC1)) begin
                next_s.ien = bus.wdata[SC1_IEN]; // RULE15
                next_s.cont = bus.wdata[SC1_CONT];
                next_s.ch = bus.wdata[SC1_CH +: 5];
                conv_complete_flag_clr = 1'b1;
                next_s.cnt = 6'h00;
                next_s.st = ((bus.wdata[SC1_CH +: 5] != CH_OFF) & ~s.trg) ? ST_SAMPLE : ST_IDLE;
            end else if (is_addr(bus, OFS_CMP_H)) begin
                next_s.cmp_h = bus.wdata;
            end else if (is_addr(bus, OFS_CMP_L)) begin
                next_s.cmp_l = bus.wdata;
            end else if (is_addr(bus, OFS_PIN1)) begin
                next_s.pin1 = bus.wdata; // RULE21
            end else if (is_addr(bus, OFS_PIN2)) begin
                next_s.pin2 = bus.wdata; // RULE21
            end
        end

        if (bus.rd) begin
            if (is_addr(bus, OFS_CONFIG)) begin
                next_s.rdata = s.cfg;
            end else if (is_addr(bus, OFS_SC2)) begin
                next_s.rdata = {s.active, s.trg, s.cfe, s.cgt, 4'h0}; // RULE13 RULE14
            end else if (is_addr(bus, OFS_SC1)) begin
                next_s.rdata = {s.conv_complete_flag, s.ien, s.cont, s.ch}; // RULE15
            end else if (is_addr(bus, OFS_RES_H)) begin
                next_s.rdata = s.res_h;
                next_s.blocked = mode10; // RULE22
            end else if (is_addr(bus, OFS_RES_L)) begin
                next_s.rdata = s.res_l;
                next_s.blocked = 1'b0;
                conv_complete_flag_clr = 1'b1;
            end else if (is_addr(bus, OFS_CMP_H)) begin
                next_s.rdata = s.cmp_h;
            end else if (is_addr(bus, OFS_CMP_L)) begin
                next_s.rdata = s.cmp_l;
            end else if (is_addr(bus, OFS_PIN1)) begin
                next_s.rdata = s.pin1;
            end else if (is_addr(bus, OFS_PIN2)) begin
                next_s.rdata = s.pin2;
            end
        end

        // set wins over clear
        next_s.conv_complete_flag = (s.conv_complete_flag & ~conv_complete_flag_clr) | conv_complete_flag_set; // RULE7
        // clock gated off: drop the conversion, results untouched
        if (halted) begin
            next_s.st = ST_IDLE; // RULE1 RULE2 RULE3
            next_s.cnt = 6'h00;
        end
        next_s.active = (next_s.st != ST_IDLE); // RULE23
        next_s.irq = next_s.conv_complete_flag & next_s.ien; // RULE7
        if (stop12_mode) begin
            next_s = RST_STATE; // RULE8
        end
    end

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            s <= RST_STATE;
        end else begin
            s <= next_s;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    assign rdata = s.rdata;
    assign irq_req = s.irq;
    assign conv_active = s.active;
    assign sample_phase = s.st[1];
    assign channel_select_field = s.ch; // RULE16
    assign pin_io_disable = {s.pin2, s.pin1}; // RULE21
    assign low_power_select = s.cfg[CFG_LP];

    ////////////////////////////////////////////////////////////////////////////
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!rstn);

    a_stop_abort_idle: assert property ( // RULE1
        stop_entry && !async_now && !stop12_mode |=> s.st == ST_IDLE && !s.active)
        else $error("stop3 entry without async clock did not abort");
    a_stop_keeps_result: assert property ( // RULE2
        halted && !stop12_mode |=> $stable(s.res_h) && $stable(s.res_l))
        else $error("result bytes changed in stop3");
    a_no_auto_resume: assert property ( // RULE3
        s.st == ST_IDLE && !bus.wr && !hw_go && !stop12_mode |=> s.st == ST_IDLE)
        else $error("converter left idle without a trigger");
    a_async_keeps_run: assert property ( // RULE4
        stop_entry && async_now && s.st != ST_IDLE && !bus.wr && !stop12_mode && !done
        |=> s.st != ST_IDLE)
        else $error("async stop3 entry aborted a conversion");
    a_cont_restart: assert property ( // RULE6
        done && !s.blocked && s.cont && !bus.wr && !halted && !stop12_mode
        |=> s.st == ST_SAMPLE)
        else $error("continuous mode did not restart");
    a_complete_irq: assert property ( // RULE7
        transfer && s.ien && !stop12_mode |=> s.conv_complete_flag && irq_req)
        else $error("completion flag or interrupt missing");
    a_deep_stop_reset: assert property ( // RULE8
        stop12_mode |=> s.cfg == RST_CONFIG && s.st == ST_IDLE && !irq_req && s.ch == CH_OFF)
        else $error("deep stop did not reset registers");
    a_sc2_reserved: assert property ( // RULE14
        bus.rd && is_addr(bus, OFS_SC2) |=> rdata[3:0] == 4'h0)
        else $error("reserved control two bits read nonzero");
    a_block_discard: assert property ( // RULE22
        done && s.blocked && !stop12_mode |=> $stable(s.res_l) && !$rose(s.conv_complete_flag))
        else $error("blocked result was transferred");
    a_active_clear: assert property ( // RULE23
        halted |=> !conv_active)
        else $error("active flag stayed set after stop3 abort");

    c_stop_abort: cover property (stop_entry && !async_now && s.st != ST_IDLE);
    c_async_done: cover property (stop3_mode && transfer);
    c_block_hit: cover property (done && s.blocked);
    c_compare_miss: cover property (done && s.cfe && !cmp_ok);
endmodule

// File: verilog/adclp_pkg.sv
// constants, layouts and state types of the converter low-power control block
package adclp_pkg;
    // register offsets
    localparam logic [3:0] OFS_CONFIG = 4'h0;
    localparam logic [3:0] OFS_SC2    = 4'h1;
    localparam logic [3:0] OFS_SC1    = 4'h2;
    localparam logic [3:0] OFS_RES_H  = 4'h3;
    localparam logic [3:0] OFS_RES_L  = 4'h4;
    localparam logic [3:0] OFS_CMP_H  = 4'h5;
    localparam logic [3:0] OFS_CMP_L  = 4'h6;
    localparam logic [3:0] OFS_PIN1   = 4'h7;
    localparam logic [3:0] OFS_PIN2   = 4'h8;
    // field positions
    localparam int CFG_LP   = 7;
    localparam int CFG_DIV  = 5;
    localparam int CFG_LSMP = 4;
    localparam int CFG_MODE = 2;
    localparam int CFG_CLK  = 0;
    localparam int SC2_ACT  = 7;
    localparam int SC2_TRG  = 6;
    localparam int SC2_CFE  = 5;
    localparam int SC2_CGT  = 4;
    localparam int SC1_CONV_COMPLETE_FLAG = 7;
    localparam int SC1_IEN  = 6;
    localparam int SC1_CONT = 5;
    localparam int SC1_CH   = 0;
    // encodings
    localparam logic [1:0] MODE_10BIT = 2'h2;
    localparam logic [1:0] CLK_BUS    = 2'h0;
    localparam logic [1:0] CLK_BUS2   = 2'h1;
    localparam logic [1:0] CLK_ALT    = 2'h2;
    localparam logic [1:0] CLK_ASYNC  = 2'h3;
    localparam logic [4:0] CH_OFF     = 5'h1f;
    localparam logic [9:0] FULL_10    = 10'h3ff;
    // sample window in half converter-clock cycles: 3.5 and 23.5 cycles
    localparam logic [5:0] SAMPLE_SHORT_HALF = 6'h07;
    localparam logic [5:0] SAMPLE_LONG_HALF  = 6'h2f;
    // successive-approximation phase, one converter clock per bit
    localparam logic [5:0] CONV_10_CYC = 6'h0a;
    localparam logic [5:0] CONV_8_CYC  = 6'h08;
    // reset values
    localparam logic [7:0] RST_CONFIG = 8'h00;
    localparam logic [7:0] RST_PIN    = 8'h00;

    typedef enum logic [2:0] {
        ST_IDLE    = 3'b001,
        ST_SAMPLE  = 3'b010,
        ST_CONVERT = 3'b100
    } adclp_state_e;

    typedef struct packed {
        logic [3:0] addr;
        logic [7:0] wdata;
        logic       wr;
        logic       rd;
    } adclp_bus_s;

    typedef struct packed {
        adclp_state_e st;
        logic [7:0]   cfg;
        logic         trg;
        logic         cfe;
        logic         cgt;
        logic         conv_complete_flag;
        logic         ien;
        logic         cont;
        logic [4:0]   ch;
        logic [7:0]   res_h;
        logic [7:0]   res_l;
        logic [7:0]   cmp_h;
        logic [7:0]   cmp_l;
        logic [7:0]   pin1;
        logic [7:0]   pin2;
        logic         blocked;
        logic [5:0]   cnt;
        logic [10:0]  sample_val;
        logic         stop3_q;
        logic         stop3_async;
        logic         active;
        logic         irq;
        logic [7:0]   rdata;
        logic         trg1;
        logic         trg2;
        logic         trg3;
    } adclp_state_s;

    localparam adclp_state_s RST_STATE = '{default: '0, st: ST_IDLE, ch: CH_OFF};

    typedef struct packed {
        logic       a1;
        logic       a2;
        logic       a3;
        logic       l1;
        logic       l2;
        logic       l3;
        logic       half;
        logic [2:0] cnt;
        logic       tick;
    } adclp_ck_s;
endpackage

// File: verilog/adclp_clkgen.sv
// converter clock source select and divider, producing one tick per converter clock
`timescale 1ns/1ns
module adclp_clkgen (
    // clock and reset
    input  wire logic       clk,
    input  wire logic       rstn,
    // control
    input  wire logic       run,
    input  wire logic [1:0] src_sel,
    input  wire logic [1:0] div_sel,
    // clock pins
    input  wire logic       async_clk_pin,
    input  wire logic       alt_clk_pin,
    // tick
    output logic            tick
);
    import adclp_pkg::*;

    adclp_ck_s s;
    adclp_ck_s next_s;
    logic      edge_in;

    function automatic logic [2:0] div_limit(input logic [1:0] d);
        case (d)
            2'h0:    div_limit = 3'h0;
            2'h1:    div_limit = 3'h1;
            2'h2:    div_limit = 3'h3;
            default: div_limit = 3'h7;
        endcase
    endfunction

    always_comb begin
        next_s = s;
        next_s.a1 = async_clk_pin;
        next_s.a2 = s.a1;
        next_s.a3 = s.a2;
        next_s.l1 = alt_clk_pin;
        next_s.l2 = s.l1;
        next_s.l3 = s.l2;
        next_s.half = ~s.half;
        next_s.tick = 1'b0;
        case (src_sel)
            CLK_BUS:  edge_in = 1'b1; // RULE12
            CLK_BUS2: edge_in = s.half;
            CLK_ALT:  edge_in = s.l2 & ~s.l3;
            default:  edge_in = s.a2 & ~s.a3;
        endcase
        if (!run) begin
            next_s.cnt = 3'h0;
        end else if (edge_in) begin
            if (s.cnt >= div_limit(div_sel)) begin // RULE12
                next_s.cnt = 3'h0;
                next_s.tick = 1'b1;
            end else begin
                next_s.cnt = s.cnt + 3'h1;
            end
        end
    end

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            s <= '0;
        end else begin
            s <= next_s;
        end
    end

    assign tick = s.tick;
endmodule

// File: testbench/adclp_far.sv
// far-side model: power-mode controller, trigger source, clock pins, analog level
`timescale 1ns/1ns
module adclp_far (
    // clock
    input  wire logic   clk,
    // power modes
    output logic        stop3_mode,
    output logic        stop12_mode,
    // pins and analog level
    output logic        hw_trigger_pin,
    output logic        async_clk_pin,
    output logic        alt_clk_pin,
    output logic [10:0] analog_level
);
    initial begin
        stop3_mode = 1'b0;
        stop12_mode = 1'b0;
        hw_trigger_pin = 1'b0;
        async_clk_pin = 1'b0;
        alt_clk_pin = 1'b0;
        analog_level = 11'h000;
    end

    ////////////////////////////////////////////////////////////////////////////
    // oscillators run free, phase unrelated to the bus clock
    always #27 async_clk_pin = ~async_clk_pin;
    always #41 alt_clk_pin = ~alt_clk_pin;

    ////////////////////////////////////////////////////////////////////////////
    // the two stop levels are never raised together
    task automatic set_stop3(input logic v);
        @(posedge clk);
        stop3_mode <= v;
    endtask

    task automatic pulse_stop12();
        @(posedge clk);
        stop12_mode <= 1'b1;
        repeat (3) @(posedge clk);
        stop12_mode <= 1'b0;
    endtask

    // held four edges so the two-flop synchroniser cannot miss it
    task automatic pulse_trigger();
        @(posedge clk);
        hw_trigger_pin <= 1'b1;
        repeat (4) @(posedge clk);
        hw_trigger_pin <= 1'b0;
    endtask

    task automatic set_level(input logic [10:0] v);
        @(posedge clk);
        analog_level <= v;
    endtask
endmodule

// File: testbench/tb.sv
// self-checking bench for the converter low-power control block
`timescale 1ns/1ns
module tb;
    import adclp_pkg::*;
    logic        clk;
    logic        rstn;
    adclp_bus_s  bus;
    logic [7:0]  rdata;
    logic        stop3_mode;
    logic        stop12_mode;
    logic        hw_trigger_pin;
    logic        async_clk_pin;
    logic        alt_clk_pin;
    logic [10:0] analog_level;
    logic        irq_req;
    logic        conv_active;
    logic        sample_phase;
    logic [4:0]  channel_select_field;
    logic [15:0] pin_io_disable;
    logic        low_power_select;
    int          bad_count;
    int          tests_run;
    int          n_samp;

    initial clk = 1'b0;
    always #5 clk = ~clk;

    adclp_far adclp_far_i (.clk(clk), .stop3_mode(stop3_mode), .stop12_mode(stop12_mode),
        .hw_trigger_pin(hw_trigger_pin), .async_clk_pin(async_clk_pin),
        .alt_clk_pin(alt_clk_pin), .analog_level(analog_level));

    adclp_ctrl adclp_ctrl_i (.clk(clk), .rstn(rstn), .bus(bus), .rdata(rdata),
        .stop3_mode(stop3_mode), .stop12_mode(stop12_mode), .hw_trigger_pin(hw_trigger_pin),
        .async_clk_pin(async_clk_pin), .alt_clk_pin(alt_clk_pin), .analog_level(analog_level),
        .irq_req(irq_req), .conv_active(conv_active), .sample_phase(sample_phase),
        .channel_select_field(channel_select_field), .pin_io_disable(pin_io_disable),
        .low_power_select(low_power_select));

    ////////////////////////////////////////////////////////////////////////////
    task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
        tests_run++;
        if (seen !== exp) begin
            bad_count++;
            $display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask

    task automatic end_of_test();
        $display("checks=%0d mismatches=%0d", tests_run, bad_count);
        if (bad_count == 0 && tests_run > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask

    // each access starts one edge late, so bus is never assigned twice in a step
    task automatic wr(input logic [3:0] a, input logic [7:0] d);
        @(posedge clk);
        bus <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
        @(posedge clk);
        bus <= '0;
    endtask

    task automatic rd(input logic [3:0] a, input logic [7:0] exp);
        @(posedge clk);
        bus <= '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
        @(posedge clk);
        bus <= '0;
        @(negedge clk);
        chk({8'h00, rdata}, {8'h00, exp});
    endtask

    // counts sample cycles until the converter falls idle
    task automatic run_done();
        int i;
        n_samp = 0;
        for (i = 0; i < 800; i++) begin
            @(negedge clk);
            if (sample_phase === 1'b1) n_samp++;
            if (conv_active !== 1'b1) break;
        end
        if (i == 800) begin
            $display("ERROR t=%0t wait ran out seen=%h exp=%h", $time, 1'b1, 1'b0);
            bad_count++;
            end_of_test();
        end
        repeat (2) @(negedge clk);
    endtask

    task automatic wait_start();
        int i;
        for (i = 0; i < 20 && conv_active !== 1'b1; i++) @(negedge clk);
        chk({15'h0, conv_active}, 16'h1);
    endtask

    ////////////////////////////////////////////////////////////////////////////
    task automatic t_regs();
        rd(OFS_CONFIG, 8'h00);
        rd(OFS_SC2, 8'h00);
        rd(OFS_SC1, 8'h1f);
        rd(4'hf, 8'h00);
        wr(OFS_CONFIG, 8'h98);
        rd(OFS_CONFIG, 8'h98);
        chk({15'h0, low_power_select}, 16'h1);
        wr(OFS_SC2, 8'hfc);
        rd(OFS_SC2, 8'h70);
        wr(OFS_SC2, 8'h00);
        wr(OFS_PIN1, 8'h02);
        wr(OFS_PIN2, 8'h80);
        repeat (2) @(negedge clk);
        chk(pin_io_disable, 16'h8002);
        $display("test regs done");
    endtask

    task automatic t_single();
        adclp_far_i.set_level(11'h400);
        wr(OFS_CONFIG, 8'h08);
        wr(OFS_SC2, 8'h00);
        wr(OFS_SC1, 8'h41);
        run_done();
        chk(n_samp[15:0], 16'h0005);
        chk({11'h0, channel_select_field}, 16'h0001);
        chk({15'h0, irq_req}, 16'h1);
        rd(OFS_SC1, 8'hc1);
        rd(OFS_RES_H, 8'h03);
        rd(OFS_RES_L, 8'hff);
        rd(OFS_SC1, 8'h41);
        chk({15'h0, conv_active}, 16'h0);
        adclp_far_i.set_level(11'h000);
        wr(OFS_CONFIG, 8'h98);
        wr(OFS_SC1, 8'h41);
        run_done();
        chk(n_samp[15:0], 16'h0019);
        rd(OFS_RES_H, 8'h00);
        rd(OFS_RES_L, 8'h00);
        $display("test single done");
    endtask

    task automatic t_block();
        adclp_far_i.set_level(11'h400);
        wr(OFS_CONFIG, 8'h22);
        wr(OFS_SC1, 8'h01);
        run_done();
        rd(OFS_RES_H, 8'h00);
        rd(OFS_RES_L, 8'hff);
        wr(OFS_CONFIG, 8'h08);
        wr(OFS_CMP_H, 8'h01);
        wr(OFS_SC2, 8'h30);
        wr(OFS_SC1, 8'h01);
        run_done();
        rd(OFS_RES_H, 8'h02);
        rd(OFS_RES_L, 8'hff);
        wr(OFS_SC2, 8'h20);
        wr(OFS_SC1, 8'h01);
        run_done();
        rd(OFS_SC1, 8'h01);
        wr(OFS_SC2, 8'h00);
        wr(OFS_SC1, 8'h01);
        run_done();
        rd(OFS_RES_H, 8'h03);
        adclp_far_i.set_level(11'h000);
        wr(OFS_SC1, 8'h01);
        repeat (60) @(posedge clk);
        rd(OFS_SC1, 8'h01);
        rd(OFS_RES_L, 8'hff);
        $display("test block done");
    endtask

    task automatic t_abort();
        int hi;
        hi = 0;
        adclp_far_i.set_level(11'h400);
        wr(OFS_CONFIG, 8'h08);
        wr(OFS_SC1, 8'h01);
        run_done();
        rd(OFS_RES_H, 8'h03);
        rd(OFS_RES_L, 8'hff);
        adclp_far_i.set_level(11'h000);
        wr(OFS_SC1, 8'h01);
        adclp_far_i.set_stop3(1'b1);
        repeat (3) @(posedge clk);
        @(negedge clk);
        chk({14'h0, conv_active, sample_phase}, 16'h0);
        repeat (10) @(posedge clk);
        adclp_far_i.set_stop3(1'b0);
        repeat (40) begin
            @(negedge clk);
            if (conv_active !== 1'b0) hi++;
        end
        chk(hi[15:0], 16'h0);
        rd(OFS_RES_H, 8'h03);
        rd(OFS_RES_L, 8'hff);
        $display("test abort done");
    endtask

    task automatic t_async();
        int rises;
        logic prev_ph;
        rises = 0;
        prev_ph = 1'b1;
        adclp_far_i.set_level(11'h400);
        wr(OFS_CONFIG, 8'h0b);
        wr(OFS_SC2, 8'h40);
        wr(OFS_SC1, 8'h41);
        adclp_far_i.pulse_trigger();
        wait_start();
        adclp_far_i.set_stop3(1'b1);
        repeat (3) @(negedge clk);
        chk({15'h0, conv_active}, 16'h1);
        run_done();
        chk({15'h0, irq_req}, 16'h1);
        adclp_far_i.set_stop3(1'b0);
        rd(OFS_RES_H, 8'h03);
        rd(OFS_RES_L, 8'hff);
        adclp_far_i.set_stop3(1'b1);
        adclp_far_i.pulse_trigger();
        wait_start();
        run_done();
        chk({15'h0, irq_req}, 16'h1);
        adclp_far_i.set_stop3(1'b0);
        rd(OFS_SC1, 8'hc1);
        rd(OFS_RES_H, 8'h03);
        rd(OFS_RES_L, 8'hff);
        wr(OFS_SC2, 8'h00);
        wr(OFS_SC1, 8'h61);
        adclp_far_i.set_stop3(1'b1);
        repeat (400) begin
            @(negedge clk);
            if (sample_phase === 1'b1 && prev_ph !== 1'b1) rises++;
            prev_ph = sample_phase;
        end
        chk({15'h0, rises >= 2}, 16'h1);
        adclp_far_i.set_stop3(1'b0);
        $display("test async done");
    endtask

    task automatic t_stop12();
        wr(OFS_CONFIG, 8'h98);
        wr(OFS_SC1, 8'h61);
        adclp_far_i.pulse_stop12();
        @(negedge clk);
        chk(pin_io_disable, 16'h0000);
        chk({14'h0, conv_active, low_power_select}, 16'h0);
        rd(OFS_CONFIG, 8'h00);
        rd(OFS_SC2, 8'h00);
        rd(OFS_SC1, 8'h1f);
        rd(OFS_RES_H, 8'h00);
        rd(OFS_RES_L, 8'h00);
        rd(OFS_PIN1, 8'h00);
        $display("test stop12 done");
    endtask

    ////////////////////////////////////////////////////////////////////////////
    initial begin
        rstn = 1'b0;
        bus = '0;
        bad_count = 0;
        tests_run = 0;
        n_samp = 0;
        repeat (2) @(posedge clk);
        rstn <= 1'b1;
        t_regs();
        t_single();
        t_block();
        t_abort();
        t_async();
        t_stop12();
        end_of_test();
    end
endmodule
